// file: spml_pkg.sv
// Purpose: shared constants, types and helpers of the servo motion loop
// Assumes: 125 MHz CLOCK, 32-bit APB register bus, two axes
// Notes: byte offsets are APB byte addresses, one aligned word per register
`default_nettype none
package spml_pkg;
  // ****************************************
  // sizes and timing
  // ****************************************
  localparam int NUM_AXES = 2;
  localparam int CLK_MHZ = 125;
  localparam int LOOP_PERIOD_US = 10000;
  localparam int LOOP_CYCLES = LOOP_PERIOD_US * CLK_MHZ;
  localparam int DRIVE_W = 16;
  localparam logic signed [31:0] DRIVE_LIMIT = 32'sd5000;
  localparam logic signed [31:0] INTEG_LIMIT = 32'sd1048576;
  localparam int GAIN_SHIFT = 8;
  localparam logic [16:0] S_FULL = 17'h10000;
  localparam logic [31:0] SIN_K = 32'h0000_4925;
  localparam logic [15:0] SIN_OFS = 16'h1000;
  localparam logic [15:0] SIN_ACC_END = 16'h2000;
  localparam logic [15:0] SIN_DEC_BEG = 16'he000;
  // ****************************************
  // register map
  // ****************************************
  localparam logic [11:0] CTRL_OFS = 12'h000;
  localparam logic [11:0] RATE_OFS = 12'h004;
  localparam logic [11:0] STATUS_OFS = 12'h008;
  localparam logic [11:0] AXIS_BASE = 12'h040;
  localparam int AXIS_SHIFT = 5;
  localparam logic [4:0] AX_KP = 5'h00;
  localparam logic [4:0] AX_KI = 5'h04;
  localparam logic [4:0] AX_KD = 5'h08;
  localparam logic [4:0] AX_TARGET = 5'h0c;
  localparam logic [4:0] AX_CENTER = 5'h10;
  localparam logic [4:0] AX_POS = 5'h14;
  localparam logic [4:0] AX_DRIVE = 5'h18;
  localparam logic [4:0] AX_ERR = 5'h1c;
  localparam int CTRL_EN = 0;
  localparam int CTRL_GO = 1;
  localparam int CTRL_PATH = 2;
  localparam int CTRL_PROF = 4;
  localparam logic [15:0] RATE_RST = 16'h0100;
  localparam logic [15:0] GAIN_RST = 16'h0000;
  // ****************************************
  // types
  // ****************************************
  typedef enum logic [1:0] {
    PATH_POINT_TO_POINT = 2'b00,
    PATH_CONTINUOUS_JOINT = 2'b01,
    PATH_CONTINUOUS_LINEAR = 2'b10,
    PATH_CONTINUOUS_CIRCULAR = 2'b11
  } spml_path_e;
  typedef enum logic {PROF_PARABOLOID = 1'b0, PROF_SINUSOID = 1'b1} spml_prof_e;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_LOAD = 2'b01,
    ST_AXIS = 2'b10,
    ST_DONE = 2'b11
  } spml_state_e;
  // quarter-wave sine in Q14, index 0..8 spans 0..90 degrees
  function automatic logic signed [15:0] spml_sin(input logic [3:0] idx);
    case (idx)
      4'h0: spml_sin = 16'sh0000;
      4'h1: spml_sin = 16'sh0c7c;
      4'h2: spml_sin = 16'sh187e;
      4'h3: spml_sin = 16'sh238e;
      4'h4: spml_sin = 16'sh2d41;
      4'h5: spml_sin = 16'sh3537;
      4'h6: spml_sin = 16'sh3b21;
      4'h7: spml_sin = 16'sh3ec5;
      default: spml_sin = 16'sh4000;
    endcase
  endfunction : spml_sin
endpackage : spml_pkg
`default_nettype wire

// file: spml_quad_counter.sv
// Purpose: quadrature encoder pulse counter for one axis
// Assumes: encoder lines are asynchronous to CLOCK
// Notes: a line change counts once the second and third stages agree
`timescale 1ns/10ps
`default_nettype none
module spml_quad_counter (
  // clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // encoder lines
  input wire logic enc_a,
  input wire logic enc_b,
  // running count
  output logic signed [31:0] count
);
  logic [2:0] a_sync_q;
  logic [2:0] b_sync_q;
  logic a_q;
  logic b_q;
  logic a_d;
  logic b_d;

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      a_sync_q <= 3'h0;
      b_sync_q <= 3'h0;
    end else begin
      a_sync_q <= {a_sync_q[1:0], enc_a};
      b_sync_q <= {b_sync_q[1:0], enc_b};
    end
  end

  // hold the last agreed level; a disagreeing pair is still settling
  always_comb begin
    a_d = (a_sync_q[1] == a_sync_q[2]) ? a_sync_q[2] : a_q;
    b_d = (b_sync_q[1] == b_sync_q[2]) ? b_sync_q[2] : b_q;
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      a_q <= 1'b0;
      b_q <= 1'b0;
      count <= 32'sh0;
    end else begin
      a_q <= a_d;
      b_q <= b_d;
      // both lines moving at once is a skipped state: no count
      if ((a_d ^ a_q) != (b_d ^ b_q)) begin
        count <= (a_q ^ b_d) ? count + 32'sh1 : count - 32'sh1;
      end
    end
  end
endmodule : spml_quad_counter
`default_nettype wire

// file: spml_servo_loop.sv
// Purpose: periodic PID servo loop with trajectory and path interpolation
// Assumes: APB master per AMBA, encoder lines asynchronous
// Notes: one axis is computed per clock inside each loop cycle
// Summary of operation
// - whole control computation repeats every 10 ms, each axis once
// - commanded position and speed formed; drive value limited to +-5000
// - encoder count sampled once per cycle; position and speed derived
// - position and speed errors are desired minus actual each cycle
// - two velocity profiles selectable: paraboloid and sinusoid
// - paraboloid ramps speed up, then down at the same rate
// - sinusoid accelerates fast, holds constant speed, decelerates fast
// - all joints scaled to start and finish together
// - path interpolated into segments, once per control cycle
// - point-to-point plus joint, straight-line and circular tool tip paths
// - position error times proportional gain added to drive
// - speed error times differential gain added to drive
// - running sum of position errors times integral gain added
// - loop fetches setpoint, reads feedback, forms error, evaluates, repeats
`timescale 1ns/10ps
`default_nettype none
module spml_servo_loop #(
  parameter int LOOP_COUNT = spml_pkg::LOOP_CYCLES
) (
  // clock and reset
  input wire logic CLOCK,
  input wire logic SYS_RST,
  // apb slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // encoders
  input wire logic [spml_pkg::NUM_AXES-1:0] ENC_A,
  input wire logic [spml_pkg::NUM_AXES-1:0] ENC_B,
  // converter drive, one signed word per axis
  output logic [spml_pkg::NUM_AXES*spml_pkg::DRIVE_W-1:0] DRIVE_OUT,
  output logic CYCLE_TICK,
  output logic MOVE_BUSY
);
  localparam int NA = spml_pkg::NUM_AXES;
  // ****************************************
  // storage
  // ****************************************
  logic en_q;
  logic [1:0] path_q;
  logic prof_q;
  logic [15:0] rate_q;
  logic [15:0] kp_q [NA];
  logic [15:0] ki_q [NA];
  logic [15:0] kd_q [NA];
  logic signed [31:0] target_q [NA];
  logic signed [31:0] center_q [NA];
  logic [15:0] kp_s [NA];
  logic [15:0] ki_s [NA];
  logic [15:0] kd_s [NA];
  logic [1:0] path_s;
  logic prof_s;
  logic signed [31:0] enc_cnt [NA];
  logic signed [31:0] enc_s [NA];
  logic signed [31:0] pos_q [NA];
  logic signed [31:0] des_q [NA];
  logic signed [31:0] start_q [NA];
  logic signed [31:0] perr_q [NA];
  logic signed [31:0] integ_q [NA];
  logic signed [15:0] drive_q [NA];
  logic [20:0] tmr_q;
  logic loop_tick;
  spml_pkg::spml_state_e st_q;
  logic [0:0] ax_q;
  logic [16:0] phase_q;
  logic [16:0] s_q;
  logic busy_q;
  logic [15:0] cyc_cnt_q;
  logic [31:0] rdata_q;
  logic err_q;
  logic wr_en;
  logic go;

  // ****************************************
  // address decode
  // ****************************************
  function automatic logic is_axis(input logic [11:0] a);
    is_axis = (a >= spml_pkg::AXIS_BASE) && (a[1:0] == 2'h0) &&
              (a < spml_pkg::AXIS_BASE + 12'(NA << spml_pkg::AXIS_SHIFT));
  endfunction : is_axis

  function automatic logic [0:0] axis_of(input logic [11:0] a);
    logic [11:0] r;
    r = (a - spml_pkg::AXIS_BASE) >> spml_pkg::AXIS_SHIFT;
    axis_of = r[0:0];
  endfunction : axis_of

  // ****************************************
  // apb slave: zero wait, read data caught in the setup cycle
  // ****************************************
  assign wr_en = PSEL && PENABLE && PWRITE;
  assign go = wr_en && (PADDR == spml_pkg::CTRL_OFS) && PWDATA[spml_pkg::CTRL_GO];
  assign PREADY = PSEL && PENABLE;
  assign PRDATA = rdata_q;
  assign PSLVERR = PSEL && PENABLE && err_q;

  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      rdata_q <= 32'h0;
      err_q <= 1'b0;
    end else if (PSEL && !PENABLE) begin
      err_q <= 1'b0;
      rdata_q <= 32'h0;
      if (PADDR == spml_pkg::CTRL_OFS) begin
        rdata_q <= {27'h0, prof_q, path_q, 1'b0, en_q};
      end else if (PADDR == spml_pkg::RATE_OFS) begin
        rdata_q <= {16'h0, rate_q};
      end else if (PADDR == spml_pkg::STATUS_OFS) begin
        rdata_q <= {cyc_cnt_q, 13'h0, st_q, busy_q};
      end else if (is_axis(PADDR)) begin
        case (PADDR[4:0])
          spml_pkg::AX_KP: rdata_q <= {16'h0, kp_q[axis_of(PADDR)]};
          spml_pkg::AX_KI: rdata_q <= {16'h0, ki_q[axis_of(PADDR)]};
          spml_pkg::AX_KD: rdata_q <= {16'h0, kd_q[axis_of(PADDR)]};
          spml_pkg::AX_TARGET: rdata_q <= target_q[axis_of(PADDR)];
          spml_pkg::AX_CENTER: rdata_q <= center_q[axis_of(PADDR)];
          spml_pkg::AX_POS: rdata_q <= pos_q[axis_of(PADDR)];
          spml_pkg::AX_DRIVE: rdata_q <= 32'(drive_q[axis_of(PADDR)]);
          default: rdata_q <= perr_q[axis_of(PADDR)];
        endcase
      end else begin
        err_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      en_q <= 1'b0;
      path_q <= 2'b00;
      prof_q <= 1'b0;
      rate_q <= spml_pkg::RATE_RST;
      for (int i = 0; i < NA; i++) begin
        kp_q[i] <= spml_pkg::GAIN_RST;
        ki_q[i] <= spml_pkg::GAIN_RST;
        kd_q[i] <= spml_pkg::GAIN_RST;
        target_q[i] <= 32'sh0;
        center_q[i] <= 32'sh0;
      end
    end else if (wr_en) begin
      if (PADDR == spml_pkg::CTRL_OFS) begin
        en_q <= PWDATA[spml_pkg::CTRL_EN];
        path_q <= PWDATA[spml_pkg::CTRL_PATH +: 2];
        prof_q <= PWDATA[spml_pkg::CTRL_PROF];
      end else if (PADDR == spml_pkg::RATE_OFS) begin
        rate_q <= PWDATA[15:0];
      end else if (is_axis(PADDR)) begin
        case (PADDR[4:0])
          spml_pkg::AX_KP: kp_q[axis_of(PADDR)] <= PWDATA[15:0];
          spml_pkg::AX_KI: ki_q[axis_of(PADDR)] <= PWDATA[15:0];
          spml_pkg::AX_KD: kd_q[axis_of(PADDR)] <= PWDATA[15:0];
          spml_pkg::AX_TARGET: target_q[axis_of(PADDR)] <= PWDATA;
          spml_pkg::AX_CENTER: center_q[axis_of(PADDR)] <= PWDATA;
          default: ;
        endcase
      end
    end
  end

  // ****************************************
  // loop timer and sequencer
  // ****************************************
  assign loop_tick = en_q && (tmr_q == 21'(LOOP_COUNT - 1));

  always_ff @(posedge CLOCK) begin
    if (SYS_RST || !en_q || loop_tick) begin
      tmr_q <= 21'h0;
    end else begin
      tmr_q <= tmr_q + 21'h1;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      st_q <= spml_pkg::ST_IDLE;
      ax_q <= 1'b0;
      cyc_cnt_q <= 16'h0;
      CYCLE_TICK <= 1'b0;
    end else begin
      CYCLE_TICK <= 1'b0;
      case (st_q)
        spml_pkg::ST_IDLE: if (loop_tick) st_q <= spml_pkg::ST_LOAD;
        spml_pkg::ST_LOAD: begin
          st_q <= spml_pkg::ST_AXIS;
          ax_q <= 1'b0;
        end
        spml_pkg::ST_AXIS: begin
          if (ax_q == 1'(NA - 1)) st_q <= spml_pkg::ST_DONE;
          ax_q <= ax_q + 1'b1;
        end
        default: begin
          st_q <= spml_pkg::ST_IDLE;
          cyc_cnt_q <= cyc_cnt_q + 16'h1;
          CYCLE_TICK <= 1'b1;
        end
      endcase
    end
  end

  // ****************************************
  // snapshot of gains, modes and encoder counts
  // ****************************************
  generate
    for (genvar g = 0; g < NA; g++) begin : g_axis
      spml_quad_counter u_enc (
        .clock(CLOCK),
        .sys_rst(SYS_RST),
        .enc_a(ENC_A[g]),
        .enc_b(ENC_B[g]),
        .count(enc_cnt[g])
      );
      assign DRIVE_OUT[g*spml_pkg::DRIVE_W +: spml_pkg::DRIVE_W] = drive_q[g];
    end
  endgenerate

  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      path_s <= 2'b00;
      prof_s <= 1'b0;
      for (int i = 0; i < NA; i++) begin
        kp_s[i] <= 16'h0;
        ki_s[i] <= 16'h0;
        kd_s[i] <= 16'h0;
        enc_s[i] <= 32'sh0;
      end
    end else if (st_q == spml_pkg::ST_LOAD) begin
      path_s <= path_q;
      prof_s <= prof_q;
      for (int i = 0; i < NA; i++) begin
        kp_s[i] <= kp_q[i];
        ki_s[i] <= ki_q[i];
        kd_s[i] <= kd_q[i];
        enc_s[i] <= enc_cnt[i];
      end
    end
  end

  // ****************************************
  // trajectory: one shared fraction keeps all joints in step
  // ****************************************
  function automatic logic [16:0] shape(input logic [16:0] ph, input logic sin_mode);
    logic [15:0] u;
    logic [15:0] w;
    logic [31:0] sq;
    logic [31:0] p;
    u = ph[15:0];
    w = 16'h0 - u;
    shape = spml_pkg::S_FULL;
    if (ph < spml_pkg::S_FULL) begin
      if (!sin_mode) begin
        sq = u[15] ? 32'(w) * 32'(w) : 32'(u) * 32'(u);
        shape = u[15] ? spml_pkg::S_FULL - 17'(sq >> 15) : sq[31:15];
      end else if (u < spml_pkg::SIN_ACC_END || u >= spml_pkg::SIN_DEC_BEG) begin
        sq = u[15] ? 32'(w) * 32'(w) : 32'(u) * 32'(u);
        p = {16'h0, sq[31:16]} * spml_pkg::SIN_K;
        shape = u[15] ? spml_pkg::S_FULL - p[28:12] : p[28:12];
      end else begin
        p = {16'h0, u - spml_pkg::SIN_OFS} * spml_pkg::SIN_K;
        shape = p[30:14];
      end
    end
  endfunction : shape

  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      phase_q <= 17'h0;
      s_q <= spml_pkg::S_FULL;
      busy_q <= 1'b0;
      for (int i = 0; i < NA; i++) start_q[i] <= 32'sh0;
    end else if (go) begin
      phase_q <= 17'h0;
      s_q <= 17'h0;
      busy_q <= 1'b1;
      for (int i = 0; i < NA; i++) start_q[i] <= des_q[i];
    end else if (st_q == spml_pkg::ST_LOAD && busy_q) begin
      if (path_q == spml_pkg::PATH_POINT_TO_POINT ||
          phase_q + 17'(rate_q) >= spml_pkg::S_FULL) begin
        phase_q <= spml_pkg::S_FULL;
        s_q <= spml_pkg::S_FULL;
        busy_q <= 1'b0;
      end else begin
        phase_q <= phase_q + 17'(rate_q);
        s_q <= shape(phase_q + 17'(rate_q), prof_q);
      end
    end
  end
  assign MOVE_BUSY = busy_q;

  // ****************************************
  // per-axis datapath for the axis in turn
  // ****************************************
  logic signed [31:0] des;
  logic signed [31:0] perr;
  logic signed [31:0] serr;
  logic signed [31:0] integ_d;
  logic signed [63:0] m;
  logic signed [63:0] rx;
  logic signed [63:0] ry;
  logic signed [63:0] sum;
  logic signed [31:0] pid;
  logic signed [15:0] sn;
  logic signed [15:0] cs;
  logic signed [31:0] dx;
  logic signed [31:0] dy;

  always_comb begin
    sn = spml_pkg::spml_sin(s_q[16:13]);
    cs = spml_pkg::spml_sin(4'h8 - s_q[16:13]);
    dx = start_q[0] - center_q[0];
    dy = start_q[1] - center_q[1];
    // circle sweeps a quarter turn about the centre on axes 0 and 1
    rx = (64'(dx) * 64'(cs) - 64'(dy) * 64'(sn)) >>> 14;
    ry = (64'(dx) * 64'(sn) + 64'(dy) * 64'(cs)) >>> 14;
    m = 64'(target_q[ax_q] - start_q[ax_q]) * $signed({47'h0, s_q});
    if (path_s == spml_pkg::PATH_POINT_TO_POINT) begin
      des = target_q[ax_q];
    end else if (path_s == spml_pkg::PATH_CONTINUOUS_CIRCULAR) begin
      des = (ax_q == 1'b0) ? center_q[0] + 32'(rx) : center_q[1] + 32'(ry);
    end else begin
      des = start_q[ax_q] + 32'(m >>> 16);
    end
    perr = des - enc_s[ax_q];
    serr = (des - des_q[ax_q]) - (enc_s[ax_q] - pos_q[ax_q]);
    integ_d = integ_q[ax_q] + perr;
    if (integ_d > spml_pkg::INTEG_LIMIT) integ_d = spml_pkg::INTEG_LIMIT;
    if (integ_d < -spml_pkg::INTEG_LIMIT) integ_d = -spml_pkg::INTEG_LIMIT;
    sum = 64'(perr) * $signed({48'h0, kp_s[ax_q]}) +
          64'(serr) * $signed({48'h0, kd_s[ax_q]}) +
          64'(integ_d) * $signed({48'h0, ki_s[ax_q]});
    sum = sum >>> spml_pkg::GAIN_SHIFT;
    if (sum > 64'(spml_pkg::DRIVE_LIMIT)) pid = spml_pkg::DRIVE_LIMIT;
    else if (sum < -64'(spml_pkg::DRIVE_LIMIT)) pid = -spml_pkg::DRIVE_LIMIT;
    else pid = 32'(sum);
  end

  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      for (int i = 0; i < NA; i++) begin
        pos_q[i] <= 32'sh0;
        des_q[i] <= 32'sh0;
        perr_q[i] <= 32'sh0;
        integ_q[i] <= 32'sh0;
        drive_q[i] <= 16'sh0;
      end
    end else if (!en_q) begin
      for (int i = 0; i < NA; i++) drive_q[i] <= 16'sh0;
    end else if (st_q == spml_pkg::ST_AXIS) begin
      pos_q[ax_q] <= enc_s[ax_q];
      des_q[ax_q] <= des;
      perr_q[ax_q] <= perr;
      integ_q[ax_q] <= integ_d;
      drive_q[ax_q] <= 16'(pid);
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (SYS_RST);

  chk_drive_range: assert property (
    drive_q[0] <= 16'sd5000 && drive_q[0] >= -16'sd5000 &&
    drive_q[1] <= 16'sd5000 && drive_q[1] >= -16'sd5000)
    else $error("drive value outside +-5000");
  chk_tick_gap: assert property (loop_tick |=> !loop_tick [*8])
    else $error("loop ticks too close");
  chk_axis_walk: assert property (
    st_q == spml_pkg::ST_LOAD |=> (st_q == spml_pkg::ST_AXIS) [*2] ##1
    st_q == spml_pkg::ST_DONE ##1 st_q == spml_pkg::ST_IDLE)
    else $error("axis sequence broken");
  chk_enc_sample: assert property (
    st_q == spml_pkg::ST_LOAD |=> enc_s[0] == $past(enc_cnt[0]) ##1
    pos_q[0] == enc_s[0])
    else $error("encoder count not sampled");
  chk_cfg_held: assert property ($changed(kp_s[0]) |-> $past(st_q) == spml_pkg::ST_LOAD)
    else $error("gain snapshot changed mid cycle");
  chk_ptp_jump: assert property (
    busy_q && st_q == spml_pkg::ST_LOAD && path_q == spml_pkg::PATH_POINT_TO_POINT && !go
    |=> s_q == spml_pkg::S_FULL && !busy_q)
    else $error("point to point move did not jump");
  chk_end_together: assert property ($fell(busy_q) |-> s_q == spml_pkg::S_FULL)
    else $error("move ended before fraction reached full");
  chk_integ_acc: assert property (
    en_q && st_q == spml_pkg::ST_AXIS && ax_q == 1'b0 && integ_d == integ_q[0] + perr
    |=> integ_q[0] == $past(integ_q[0]) + $past(perr))
    else $error("integrator did not accumulate");
  chk_drive_zero: assert property ($rose(en_q) |-> drive_q[0] == 16'sh0)
    else $error("drive not zero before first cycle");
  chk_sat_hit: assert property (
    en_q && st_q == spml_pkg::ST_AXIS && ax_q == 1'b0 && sum > 64'sd5000
    |=> drive_q[0] == 16'sd5000)
    else $error("drive not saturated high");

  cov_move_start: cover property (go ##1 busy_q);
  cov_move_end: cover property ($fell(busy_q));
  cov_saturate: cover property (drive_q[0] == 16'sd5000);
  cov_circle: cover property (busy_q && path_s == spml_pkg::PATH_CONTINUOUS_CIRCULAR);
endmodule : spml_servo_loop
`default_nettype wire

// file: spml_motor_model.sv
// Purpose: shaft encoder and drive stage stand-in for two axes
// Assumes: run[i] high advances axis i by one count every 8 clocks
// Notes: pwm output is free-running and is not compared by the bench
`timescale 1ns/10ps
`default_nettype none
module spml_motor_model #(
  parameter int PWM_PERIOD = 3788
) (
  // clock
  input wire logic clock,
  // stimulus and converter word
  input wire logic [1:0] run,
  input wire logic [31:0] drive,
  // encoder and power stage
  output logic [1:0] enc_a,
  output logic [1:0] enc_b,
  output logic [1:0] pwm
);
  logic [2:0] div_q [2] = '{3'h0, 3'h0};
  logic [1:0] ph_q [2] = '{2'h0, 2'h0};
  logic [11:0] pwm_cnt_q = 12'h000;
  // 125 MHz over the period gives the fixed 33 kHz switching rate
  always_ff @(posedge clock) begin
    pwm_cnt_q <= (pwm_cnt_q >= 12'(PWM_PERIOD - 1)) ? 12'h000 : pwm_cnt_q + 12'h001;
  end
  for (genvar i = 0; i < 2; i++) begin : g_ax
    // slow steps so the design's three-flop synchroniser sees every edge
    always_ff @(posedge clock) begin
      div_q[i] <= run[i] ? div_q[i] + 3'h1 : 3'h0;
      if (run[i] && div_q[i] == 3'h7) begin
        ph_q[i] <= ph_q[i] + 2'h1;
      end
    end
    assign enc_a[i] = ph_q[i][1];
    assign enc_b[i] = ph_q[i][1] ^ ph_q[i][0];
    // duty follows the difference between word and mid-scale
    assign pwm[i] = (int'(pwm_cnt_q) * 10000) <
                    ((int'($signed(drive[16*i+:16])) + 5000) * PWM_PERIOD);
  end
endmodule : spml_motor_model
`default_nettype wire

// file: tb.sv
// Purpose: self-checking bench of the servo loop over APB
// Assumes: LOOP_COUNT shortened to 40 clocks per loop cycle
// Notes: gains of 0x100 give unity after the design's shift of 8
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rdv, drive, d1;
  logic pready, pslverr, tick, busy, errv, seen;
  logic [1:0] run = 2'b00;
  logic [1:0] enc_a, enc_b;
  int failures = 0;
  int samples_checked = 0;
  int cycles = 0;
  int gap = 0;
  always #4 clk = ~clk;
  spml_servo_loop #(.LOOP_COUNT(40)) dut_u (.CLOCK(clk), .SYS_RST(rst), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .ENC_A(enc_a), .ENC_B(enc_b), .DRIVE_OUT(drive),
    .CYCLE_TICK(tick), .MOVE_BUSY(busy));
  spml_motor_model motor_u (.clock(clk), .run(run), .drive(drive), .enc_a(enc_a),
    .enc_b(enc_b), .pwm());
  // ****************************************
  // tasks
  // ****************************************
  task automatic tally_and_finish();
    if (failures == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : tally_and_finish
  always @(posedge clk) begin
    cycles++;
    if (cycles == 10000) begin
      failures++;
      tally_and_finish();
    end
  end
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rdv = prdata;
    errv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [31:0] exp, input string nm);
    apb(1'b0, a, 32'h0);
    chk(nm, exp, rdv);
  endtask : rd
  // gap counts edges since the last of the n waits began, so two calls in a row give one period
  task automatic wtick(input int n);
    repeat (n) begin
      gap = 0;
      do begin
        @(posedge clk);
        gap++;
      end while (tick !== 1'b1);
    end
  endtask : wtick
  function automatic logic [11:0] ax(input int n, input logic [4:0] o);
    return spml_pkg::AXIS_BASE + 12'(n << spml_pkg::AXIS_SHIFT) + 12'(o);
  endfunction : ax
  function automatic logic [31:0] dv(input int n);
    return {{16{drive[16*n+15]}}, drive[16*n+:16]};
  endfunction : dv
  // ****************************************
  // sequence
  // ****************************************
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk("drive_rst", 32'h0, drive);
    rd(spml_pkg::RATE_OFS, {16'h0, spml_pkg::RATE_RST}, "rate_rst");
    rd(ax(1, spml_pkg::AX_KP), 32'h0, "kp1_rst");
    apb(1'b0, 12'h0fc, 32'h0);
    chk("slverr", 32'h1, {31'h0, errv});
    wr(ax(0, spml_pkg::AX_KI), 32'h100);
    wr(ax(0, spml_pkg::AX_TARGET), 32'd40);
    wr(spml_pkg::CTRL_OFS, 32'h3);
    wtick(2);
    d1 = dv(0);
    wtick(1);
    chk("integ_step", 32'd40, dv(0) - d1);
    chk("period", 32'd40, 32'(gap));
    wr(ax(0, spml_pkg::AX_KI), 32'h0);
    wr(ax(0, spml_pkg::AX_KD), 32'h100);
    wr(ax(0, spml_pkg::AX_TARGET), 32'hffffffe2);
    wr(spml_pkg::CTRL_OFS, 32'h3);
    seen = 1'b0;
    repeat (3) begin
      wtick(1);
      if (dv(0) === 32'hffffffba) seen = 1'b1;
    end
    chk("kd_kick", 32'h1, {31'h0, seen});
    chk("kd_rest", 32'h0, dv(0));
    wr(ax(0, spml_pkg::AX_KD), 32'h0);
    wr(ax(0, spml_pkg::AX_KP), 32'h100);
    wr(ax(1, spml_pkg::AX_KP), 32'h200);
    wr(ax(0, spml_pkg::AX_TARGET), 32'h000186a0);
    wr(ax(1, spml_pkg::AX_TARGET), 32'd7);
    wr(spml_pkg::CTRL_OFS, 32'h3);
    wtick(2);
    chk("clamp_hi", 32'd5000, dv(0));
    chk("kp_axis1", 32'd14, dv(1));
    rd(ax(1, spml_pkg::AX_ERR), 32'd7, "err1");
    wr(ax(0, spml_pkg::AX_TARGET), 32'hfffe7960);
    wr(spml_pkg::CTRL_OFS, 32'h3);
    wtick(2);
    chk("clamp_lo", 32'hffffec78, dv(0));
    wr(ax(0, spml_pkg::AX_TARGET), 32'h0);
    wr(spml_pkg::CTRL_OFS, 32'h3);
    run <= 2'b01;
    repeat (80) @(posedge clk);
    run <= 2'b00;
    wtick(2);
    chk("enc_drive", 32'hfffffff6, dv(0));
    rd(ax(0, spml_pkg::AX_POS), 32'd10, "pos0");
    wr(spml_pkg::RATE_OFS, 32'h4000);
    wr(ax(1, spml_pkg::AX_TARGET), 32'd100);
    for (int pf = 0; pf < 2; pf++) begin
      for (int pt = 1; pt < 4; pt++) begin
        wr(ax(0, spml_pkg::AX_TARGET), 32'(pt * 50 + pf * 20));
        wr(spml_pkg::CTRL_OFS, 32'((pf << 4) | (pt << 2) | 3));
        wtick(1);
        // first quarter of phase: paraboloid gives 1/8 of the move, sinusoid more
        if (pt == 1) begin
          chk("prof0", (pf == 1) ? 32'hffffffb6 : 32'hfffffffc, dv(0));
        end
        wtick(1);
        chk("busy_mid", 32'h1, {31'h0, busy});
        wtick(6);
        chk("busy_end", 32'h0, {31'h0, busy});
        // circle about the origin ends a quarter turn on: x becomes -y, y becomes x
        chk("end0", (pt == 3) ? 32'hffffff92 : 32'(pt * 50 + pf * 20 - 10), dv(0));
        chk("end1", (pt == 3 && pf == 1) ? 32'd240 : 32'd200, dv(1));
      end
    end
    wr(spml_pkg::CTRL_OFS, 32'h0);
    repeat (2) @(posedge clk);
    chk("drive_off", 32'h0, drive);
    tally_and_finish();
  end
endmodule : tb
`default_nettype wire
